// ### verilog/adc_mode_ctrl.sv
// Pin-driven calibration, standby and power-down control with an APB view.
`include "adc_mode_defs.svh"

module adc_mode_ctrl #(
  parameter logic [31:0] CONV_FAST_CYC =
    32'((64'd`CONV_FAST_NS * 64'd`PCLK_MHZ + 64'd999) / 64'd1000),
  parameter logic [31:0] CONV_SLOW_CYC =
    32'((64'd`CONV_SLOW_NS * 64'd`PCLK_MHZ + 64'd999) / 64'd1000),
  parameter logic [31:0] CAL_FAST_CYC =
    32'((64'd`CAL_FAST_NS * 64'd`PCLK_MHZ + 64'd999) / 64'd1000),
  parameter logic [31:0] CAL_SLOW_CYC =
    32'((64'd`CAL_SLOW_NS * 64'd`PCLK_MHZ + 64'd999) / 64'd1000),
  parameter logic [31:0] EXIT_FAST_CYC =
    32'((64'd`STBY_EXIT_FAST_NS * 64'd`PCLK_MHZ + 64'd999) / 64'd1000),
  parameter logic [31:0] EXIT_SLOW_CYC =
    32'((64'd`STBY_EXIT_SLOW_NS * 64'd`PCLK_MHZ + 64'd999) / 64'd1000),
  parameter logic [31:0] XCAL_FAST_CYC =
    32'((64'd`STBY_CAL_FAST_NS * 64'd`PCLK_MHZ + 64'd999) / 64'd1000),
  parameter logic [31:0] XCAL_SLOW_CYC =
    32'((64'd`STBY_CAL_SLOW_NS * 64'd`PCLK_MHZ + 64'd999) / 64'd1000)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        shift_clock_pin,
  input  wire logic        shutdown_n_pin,
  output logic             ready_dataout_pin
);

  localparam logic [11:0] STBY_ACT_CYC =
    12'((`STBY_ACT_NS * `PCLK_MHZ + 999) / 1000);
  localparam logic [31:0] WAKE_INT_CYC =
    32'((`WAKE_INT_NS * `PCLK_MHZ + 999) / 1000);
  localparam logic [31:0] WAKE_EXT_CYC =
    32'((`WAKE_EXT_NS * `PCLK_MHZ + 999) / 1000);
  localparam adc_mode_pkg::ctl_t RST_VAL = '{state: adc_mode_pkg::ST_WAKE,
                                              dout:  1'b1,
                                              default: '0};

  adc_mode_pkg::ctl_t st_reg;
  adc_mode_pkg::ctl_t st_next;
  logic               rise;
  logic               fall;
  logic               speed;
  logic [31:0]        conv_load;

  // Decodes a byte address into a register hit.
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `OFF_CTRL) || (a == `OFF_SAMPLE) || (a == `OFF_STATUS);
  endfunction

  // Picks the fast or slow count of a timing pair, loaded as count minus one.
  function automatic logic [31:0] pick(input logic        fast,
                                       input logic [31:0] f,
                                       input logic [31:0] s);
    pick = fast ? f - 32'h1 : s - 32'h1;
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.sclk1 = shift_clock_pin;
    st_next.sclk2 = st_reg.sclk1;
    st_next.sclk3 = st_reg.sclk2;
    st_next.shdn1 = shutdown_n_pin;
    st_next.shdn2 = st_reg.shdn1;
    rise = st_reg.sclk2 & ~st_reg.sclk3;
    fall = ~st_reg.sclk2 & st_reg.sclk3;
    speed = st_reg.ctrl[`CTRL_SPEED_BIT];
    conv_load = pick(speed, CONV_FAST_CYC, CONV_SLOW_CYC);

    // APB slave: setup cycle prepares the answer, access phase is one cycle.
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    if (psel && !penable) begin
      st_next.pready = 1'b1;
      st_next.pslverr = !reg_hit(paddr);
      unique case (paddr)
        `OFF_CTRL:   st_next.prdata = {30'h0, st_reg.ctrl};
        `OFF_SAMPLE: st_next.prdata = {12'h0, st_reg.sample};
        `OFF_STATUS: st_next.prdata = {19'h0, st_reg.bitcnt, 3'h0,
                                       !st_reg.shdn2, st_reg.cal_after,
                                       st_reg.seen, st_reg.state};
        default:     st_next.prdata = 32'h0;
      endcase
    end
    if (psel && penable && st_reg.pready && pwrite) begin
      if (paddr == `OFF_CTRL) begin
        st_next.ctrl = pwdata[1:0];
      end
      if (paddr == `OFF_SAMPLE) begin
        st_next.sample = pwdata[19:0];
      end
    end

    // Converter mode sequencing.
    unique case (st_reg.state)
      adc_mode_pkg::ST_WAKE, adc_mode_pkg::ST_CAL: begin
        if (st_reg.timer == 32'h0) begin
          st_next.state = adc_mode_pkg::ST_CONV;
          st_next.dout = 1'b0;
          st_next.shift = {st_reg.sample, `TRAIL_ONES};
          st_next.bitcnt = 5'h0;
          st_next.seen = 1'b1;
          st_next.high_cnt = 12'h0;
          st_next.timer = conv_load;
        end else begin
          st_next.timer = st_reg.timer - 32'h1;
        end
      end
      adc_mode_pkg::ST_CONV: begin
        if (st_reg.timer == 32'h0) begin
          st_next.dout = 1'b0;
          st_next.shift = {st_reg.sample, `TRAIL_ONES};
          st_next.bitcnt = 5'h0;
          st_next.seen = 1'b1;
          st_next.timer = conv_load;
        end else begin
          st_next.timer = st_reg.timer - 32'h1;
          if (st_reg.seen && rise) begin
            if (st_reg.bitcnt != 5'h1F) begin
              st_next.bitcnt = st_reg.bitcnt + 5'h1;
            end
            if (st_reg.bitcnt < 5'(`FRAME_BITS)) begin
              st_next.dout = st_reg.shift[23];
              st_next.shift = {st_reg.shift[22:0], 1'b1};
            end else begin
              st_next.dout = 1'b1;
            end
          end
          if (st_reg.seen && fall && st_reg.bitcnt == 5'd26) begin
            st_next.state = adc_mode_pkg::ST_CAL;
            st_next.dout = 1'b1;
            st_next.seen = 1'b0;
            st_next.timer = pick(speed, CAL_FAST_CYC, CAL_SLOW_CYC);
          end
        end
        if (st_reg.seen && st_reg.sclk2) begin
          st_next.high_cnt = st_reg.high_cnt + 12'h1;
          if (st_reg.high_cnt == STBY_ACT_CYC - 12'h1) begin
            st_next.state = adc_mode_pkg::ST_STBY;
            st_next.dout = 1'b1;
            st_next.seen = 1'b0;
            st_next.cal_after = (st_reg.bitcnt >= 5'd25);
          end
        end else begin
          st_next.high_cnt = 12'h0;
        end
      end
      adc_mode_pkg::ST_STBY: begin
        st_next.dout = 1'b1;
        st_next.high_cnt = 12'h0;
        if (!st_reg.sclk2) begin
          st_next.state = adc_mode_pkg::ST_CAL;
          st_next.timer = st_reg.cal_after ?
            pick(speed, XCAL_FAST_CYC, XCAL_SLOW_CYC) :
            pick(speed, EXIT_FAST_CYC, EXIT_SLOW_CYC);
          st_next.cal_after = 1'b0;
        end
      end
    endcase

    if (!st_reg.shdn2) begin
      st_next.state = adc_mode_pkg::ST_WAKE;
      st_next.timer = st_reg.ctrl[`CTRL_EXTCLK_BIT] ?
        WAKE_EXT_CYC - 32'h1 : WAKE_INT_CYC - 32'h1;
      st_next.bitcnt = 5'h0;
      st_next.shift = 24'h0;
      st_next.dout = 1'b1;
      st_next.seen = 1'b0;
      st_next.cal_after = 1'b0;
      st_next.high_cnt = 12'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= RST_VAL;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign ready_dataout_pin = st_reg.dout;

endmodule // adc_mode_ctrl

// ### verilog/adc_mode_defs.svh
// Constants and functional notes for the converter mode controller.
// Functional notes
// - The 25th shift clock after data ready keeps the output high.
// - Falling edge of the 26th shift clock starts offset calibration.
// - Calibration end drives the output low to flag new data.
// - First result after calibration is settled and delivered as is.
// - Calibration to data ready is 101.28 ms fast or 801.02 ms slow.
// - Mode times are set for 4.9152 MHz and scale by parameter.
// - Shift clock held high 20 us after data ready enters standby.
// - Standby is accepted at any point of the readback.
// - Output stays high in standby; host keeps the clock high.
// - Clock low wakes from standby; the first result is valid.
// - Plain standby exit gives data ready after 52.51 or 401.8 ms.
// - Clocks to the 25th then standby runs calibration on wake-up.
// - Standby exit with calibration gives data ready after 103 or 803 ms.
// - Shutdown pin low powers the converter down.
// - Power-down resets all converter state; the ctrl and sample registers keep their values.
// - Power-down is accepted at any point of the readback.
// - Shutdown pulse at least 26 us; wake takes 7.95 or 0.16 us.
// - Data ready drives the output low; bits go out MSB first on rises.
// - Shift clocks 21 to 24 each output a one.
// - Rate select low picks 10 SPS timing, high picks 80 SPS.
`ifndef ADC_MODE_DEFS_SVH
`define ADC_MODE_DEFS_SVH

`define PCLK_MHZ           125
`define CONV_FAST_NS       12500000
`define CONV_SLOW_NS       100000000
`define CAL_FAST_NS        101280000
`define CAL_SLOW_NS        801020000
`define STBY_EXIT_FAST_NS  52510000
`define STBY_EXIT_SLOW_NS  401800000
`define STBY_CAL_FAST_NS   103000000
`define STBY_CAL_SLOW_NS   803000000
`define STBY_ACT_NS        20000
`define WAKE_INT_NS        7950
`define WAKE_EXT_NS        160

`define OFF_CTRL           8'h00
`define OFF_SAMPLE         8'h04
`define OFF_STATUS         8'h08
`define CTRL_SPEED_BIT     0
`define CTRL_EXTCLK_BIT    1
`define DATA_BITS          20
`define FRAME_BITS         24
`define TRAIL_ONES         4'hF

`endif

// ### verilog/adc_mode_pkg.sv
// Types for the converter mode controller.
package adc_mode_pkg;

  typedef enum logic [1:0] {
    ST_WAKE = 2'b00,
    ST_CONV = 2'b01,
    ST_STBY = 2'b11,
    ST_CAL  = 2'b10
  } mode_state_t;

  typedef struct packed {
    mode_state_t state;
    logic [31:0] timer;
    logic [4:0]  bitcnt;
    logic [23:0] shift;
    logic        dout;
    logic        seen;
    logic        cal_after;
    logic [11:0] high_cnt;
    logic        sclk1;
    logic        sclk2;
    logic        sclk3;
    logic        shdn1;
    logic        shdn2;
    logic [1:0]  ctrl;
    logic [19:0] sample;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ctl_t;

endpackage

// ### tb/adc_mode_ctrl_assertions.sv
// Port assertions for the converter mode controller.
module adc_mode_ctrl_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        shift_clock_pin,
  input wire logic        shutdown_n_pin,
  input wire logic        ready_dataout_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] hi_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_cnt <= 12'h000;
    else if (!shift_clock_pin) hi_cnt <= 12'h000;
    else if (hi_cnt != 12'hFFF) hi_cnt <= hi_cnt + 12'h001;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access; psel && penable; endsequence
  sequence s_shdn_held; !shutdown_n_pin [*4]; endsequence
  a_access_ready: assert property (($rose(penable) && psel) |-> pready)
    else $error("no ready in first access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_in_access: assert property (pready |-> s_access)
    else $error("ready outside access");
  a_unmapped_err: assert property
    ((pready && !(paddr inside {8'h00, 8'h04, 8'h08})) |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property
    ((pready && (paddr inside {8'h00, 8'h04, 8'h08})) |-> !pslverr)
    else $error("mapped access with error");
  a_err_zero: assert property ((pslverr && !pwrite) |-> prdata == 32'h0)
    else $error("error read not zero");
  a_shdn_idle: assert property (s_shdn_held |-> ready_dataout_pin)
    else $error("output low in shutdown");
  a_wake_hold: assert property ($rose(shutdown_n_pin) |-> ready_dataout_pin [*8])
    else $error("data ready too soon after shutdown");
  a_standby_high: assert property (hi_cnt > 12'd2600 |-> ready_dataout_pin)
    else $error("output low in standby");
endmodule // adc_mode_ctrl_assertions

bind adc_mode_ctrl adc_mode_ctrl_assertions u_adc_mode_ctrl_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .shift_clock_pin(shift_clock_pin),
  .shutdown_n_pin(shutdown_n_pin), .ready_dataout_pin(ready_dataout_pin));

// ### tb/adc_host_model.sv
// Host model that drives the shift clock and the shutdown pin.
module adc_host_model (
  input  wire logic pclk,
  input  wire logic ready_dataout_pin,
  output logic      shift_clock_pin,
  output logic      shutdown_n_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    shift_clock_pin = 1'b0;
    shutdown_n_pin  = 1'b0;
  end
  task automatic pulse(output logic b);
    shift_clock_pin <= 1'b1;
    repeat (5) @(posedge pclk);
    shift_clock_pin <= 1'b0;
    repeat (5) @(posedge pclk);
    b = ready_dataout_pin;
  endtask
  task automatic level(input logic v);
    shift_clock_pin <= v;
  endtask
  task automatic set_shdn(input logic v);
    shutdown_n_pin <= v;
  endtask
endmodule // adc_host_model

// ### tb/adc_mode_ctrl_tb.sv
// Self-checking bench for the converter mode controller.
module adc_mode_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL_F = 700, CAL_S = 900, EXIT_F = 500, XCAL_F = 1100;
  logic        pclk = 1'b0, presetn, psel, penable;
  logic        pwrite, pready, pslverr, err, b;
  logic        shift_clock_pin, shutdown_n_pin, ready_dataout_pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] s;
  int          errors = 0, num_checks = 0, n, r, k;
  always #4 pclk = ~pclk;
  adc_mode_ctrl #(.CONV_FAST_CYC(32'd3000), .CAL_FAST_CYC(CAL_F),
    .CAL_SLOW_CYC(CAL_S), .EXIT_FAST_CYC(EXIT_F),
    .XCAL_FAST_CYC(XCAL_F)) u_adc_mode_ctrl (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shift_clock_pin(shift_clock_pin),
    .shutdown_n_pin(shutdown_n_pin), .ready_dataout_pin(ready_dataout_pin));
  adc_host_model u_adc_host_model (.pclk(pclk),
    .ready_dataout_pin(ready_dataout_pin), .shift_clock_pin(shift_clock_pin),
    .shutdown_n_pin(shutdown_n_pin));
  task automatic close_out();
    if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: value %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chk_time(input int got, input int exp);
    num_checks++;
    if (got < exp || got > exp + 10) begin
      errors++;
      $display("unexpected at %0t: %0d cycles, want %0d", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin errors++; close_out(); end
    rd = prdata; err = pslverr; psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_low(output int c);
    c = 0;
    while (ready_dataout_pin !== 1'b0 && c < 9000) begin @(posedge pclk); c++; end
    if (c >= 9000) begin errors++; close_out(); end
  endtask
  task automatic frame(input logic [19:0] v);
    logic [23:0] e;
    e = {v, 4'hF};
    for (int i = 23; i >= 0; i--) begin
      u_adc_host_model.pulse(b);
      chk_word({31'h0, b}, {31'h0, e[i]});
    end
  endtask
  task automatic new_sample();
    s = 20'($urandom);
    apb(1'b1, 8'h04, {12'h0, s});
  endtask
  initial begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    void'($urandom(42567));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    u_adc_host_model.set_shdn(1'b1);
    apb(1'b0, 8'h0C, 32'h0);
    chk_word({31'h0, err}, 32'h1);
    chk_word(rd, 32'h0);
    for (r = 1; r >= 0; r--) begin
      apb(1'b1, 8'h00, {30'h0, 1'b1, r[0]});
      new_sample();
      wait_low(n);
      frame(s);
      u_adc_host_model.pulse(b);
      chk_word({31'h0, b}, 32'h1);
      u_adc_host_model.pulse(b);
      apb(1'b0, 8'h08, 32'h0);
      chk_word(rd & 32'h3, 32'h2);
      new_sample();
      wait_low(n);
      chk_time(n + 11, r ? CAL_F : CAL_S);
      frame(s);
    end
    // Mid-run reset also skips the long slow-rate conversion period.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk_word(rd, 32'h0);
    apb(1'b1, 8'h00, 32'h3);
    for (k = 0; k < 2; k++) begin
      new_sample();
      wait_low(n);
      if (k == 1) frame(s);
      else repeat (3) u_adc_host_model.pulse(b);
      u_adc_host_model.level(1'b1);
      repeat (2600) @(posedge pclk);
      apb(1'b0, 8'h08, 32'h0);
      chk_word(rd & 32'h3, 32'h3);
      chk_word({31'h0, ready_dataout_pin}, 32'h1);
      new_sample();
      u_adc_host_model.level(1'b0);
      wait_low(n);
      chk_time(n, k ? XCAL_F : EXIT_F);
      frame(s);
    end
    new_sample();
    wait_low(n);
    repeat (5) u_adc_host_model.pulse(b);
    u_adc_host_model.set_shdn(1'b0);
    repeat (3250) @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    chk_word(rd & 32'h1F1F, 32'h10);
    chk_word({31'h0, ready_dataout_pin}, 32'h1);
    u_adc_host_model.set_shdn(1'b1);
    wait_low(n);
    chk_time(n, 20);
    apb(1'b0, 8'h00, 32'h0);
    chk_word(rd & 32'h3, 32'h3);
    close_out();
  end
endmodule // adc_mode_ctrl_tb
